// ==== slpc_ctrl.sv ====
// Sleep-mode, wake-up and reset control for the microcontroller core.
`include "slpc_cfg.svh"
`default_nettype none
module slpc_ctrl (
   input wire logic mclk_i, // Core clock, 25 MHz.
   input wire logic reset_n_i, // Power-on reset, active low.
   input wire logic ext_reset_n_i, // External reset pin, active low.
   input wire logic sleep_req_i, // CPU sleep instruction, one-cycle pulse.
   input wire logic sleep_en_i, // Sleep enable from CPU control.
   input wire logic [2:0] sleep_mode_i, // Selected sleep mode code.
   input wire logic ext_irq_i, // External interrupt level, asynchronous.
   input wire logic per_irq_i, // Interrupt from a running peripheral.
   input wire logic timer_irq_i, // Asynchronous timer interrupt.
   input wire logic test_en_i, // Test-access interface enabled.
   input wire logic tap_shift_i, // Test controller in a shift-out state.
   input wire logic [31:0] port_oe_n_i, // Port output enables, low drives.
   output logic [31:0] port_oe_n_o, // Port output enables to pads, low drives.
   output logic tdo_oe_n_o, // Test data output enable, low drives.
   output logic [2:0] test_pu_o, // Pull-ups on test data, mode, clock pins.
   output logic cpu_clk_en_o, // CPU clock gate.
   output logic io_clk_en_o, // General peripheral clock gate.
   output logic adc_clk_en_o, // Converter clock gate.
   output logic async_tmr_en_o, // Asynchronous timer enable.
   output logic osc_en_o, // Main oscillator enable.
   output logic sys_reset_n_o, // Internal reset to the core, active low.
   output logic asleep_o // Device is in a sleep mode.
);
   // Settle and hold counts, cut to the width of the shared counter.
   localparam logic [`SLPC_CNT_W-1:0] OSC_CYC = `SLPC_CNT_W'(`SLPC_OSC_START_CYC);
   localparam logic [`SLPC_CNT_W-1:0] RST_CYC = `SLPC_CNT_W'(`SLPC_RST_MIN_CYC);

   // Registers and their next values.
   logic rst_pin_s;
   logic ext_irq_s;
   logic timer_irq_s;
   slpc_pkg::slpc_state_t state_reg, state_next;
   logic [`SLPC_CNT_W-1:0] cnt_reg, cnt_next;
   logic [2:0] mode_reg, mode_next;
   logic [4:0] gate_reg, gate_next;
   logic sys_rst_n_reg, sys_rst_n_next;
   logic cpu_en_reg, cpu_en_next;
   logic asleep_reg, asleep_next;
   logic in_reset;
   logic wake;
   logic [31:0] port_oe_n_reg, port_oe_n_next;
   logic tdo_oe_n_reg, tdo_oe_n_next;
   logic [2:0] test_pu_reg, test_pu_next;

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers; the reset pin itself also acts asynchronously below.
   slpc_sync u_rst_sync (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .d_i(~ext_reset_n_i),
      .q_o(rst_pin_s)
   );
   slpc_sync u_irq_sync (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .d_i(ext_irq_i),
      .q_o(ext_irq_s)
   );
   // The asynchronous timer runs from its own oscillator, so its request crosses over.
   slpc_sync u_tmr_sync (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .d_i(timer_irq_i),
      .q_o(timer_irq_s)
   );

   // Either reset source holds the pad logic reset, with or without clock.
   assign in_reset = ~reset_n_i | ~ext_reset_n_i;

   ////////////////////////////////////////////////////////////////////////////
   // Port enables follow the core and test pads the test interface while no reset is active.
   always_comb begin
      port_oe_n_next = port_oe_n_i;
      tdo_oe_n_next = ~(test_en_i & tap_shift_i);
      test_pu_next = {3{test_en_i}};
   end

   // The reset branch needs no clock, so the pads float even with the oscillator stopped.
   always_ff @(posedge mclk_i or posedge in_reset) begin
      if (in_reset) begin
         port_oe_n_reg <= 32'hFFFFFFFF;
         tdo_oe_n_reg <= 1'b1;
         test_pu_reg <= 3'h7;
      end else begin
         port_oe_n_reg <= port_oe_n_next;
         tdo_oe_n_reg <= tdo_oe_n_next;
         test_pu_reg <= test_pu_next;
      end
   end
   // Pull-ups stay on in reset; the enable setting is lost by power-on or by the external reset pin.
   assign port_oe_n_o = port_oe_n_reg;
   assign tdo_oe_n_o = tdo_oe_n_reg;
   assign test_pu_o = test_pu_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Wake sources depend on which logic still runs in the held mode.
   // A source whose logic is stopped in that mode cannot raise a request.
   always_comb begin
      wake = ext_irq_s;
      unique case (mode_reg)
         `SLPC_MODE_IDLE: wake = ext_irq_s | per_irq_i | timer_irq_s;
         `SLPC_MODE_NOISE: wake = ext_irq_s | per_irq_i | timer_irq_s;
         `SLPC_MODE_PSAVE, `SLPC_MODE_XSTBY: wake = ext_irq_s | timer_irq_s;
         default: wake = ext_irq_s;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer. Gate bits: cpu, io, adc, async timer, osc.
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      mode_next = mode_reg;
      gate_next = gate_reg;
      sys_rst_n_next = sys_rst_n_reg;
      unique case (state_reg)
         slpc_pkg::ST_RUN: begin
            gate_next = 5'h1F;
            sys_rst_n_next = 1'b1;
            if (sleep_req_i && sleep_en_i) begin
               mode_next = sleep_mode_i;
               state_next = slpc_pkg::ST_SLEEP;
               // Each mode keeps the clocks that its wake sources need; all but power-down and power-save also keep the oscillator.
               unique case (sleep_mode_i)
                  `SLPC_MODE_IDLE: gate_next = 5'h1E;
                  `SLPC_MODE_NOISE: gate_next = 5'h1C;
                  `SLPC_MODE_PDOWN: gate_next = 5'h00;
                  `SLPC_MODE_PSAVE: gate_next = 5'h08;
                  `SLPC_MODE_STBY: gate_next = 5'h10;
                  `SLPC_MODE_XSTBY: gate_next = 5'h18;
                  // Unused codes are ignored and the core keeps running.
                  default: state_next = slpc_pkg::ST_RUN;
               endcase
            end
         end
         slpc_pkg::ST_SLEEP: begin
            // A warm oscillator lets the core restart with no settle wait.
            if (wake) begin
               cnt_next = '0;
               gate_next = gate_reg | 5'h10;
               state_next = gate_reg[4] ? slpc_pkg::ST_RUN : slpc_pkg::ST_OSC_WAIT;
            end
         end
         slpc_pkg::ST_OSC_WAIT: begin
            // Hold the CPU until the restarted oscillator has settled.
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == OSC_CYC - 1'b1) begin
               state_next = slpc_pkg::ST_RUN;
            end
         end
         slpc_pkg::ST_RESET: begin
            // Hold internal reset a settle time after the pin is released.
            gate_next = 5'h1E;
            sys_rst_n_next = 1'b0;
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == RST_CYC - 1'b1) begin
               state_next = slpc_pkg::ST_RUN;
            end
         end
         default: state_next = slpc_pkg::ST_RESET;
      endcase
      // A pin reset seen through the synchroniser overrides any state.
      if (rst_pin_s) begin
         state_next = slpc_pkg::ST_RESET;
         cnt_next = '0;
         sys_rst_n_next = 1'b0;
      end
      // Outputs leave flip-flops, so they are derived from the next state.
      cpu_en_next = gate_next[0] & (state_next == slpc_pkg::ST_RUN);
      asleep_next = (state_next == slpc_pkg::ST_SLEEP);
   end

   // External reset is also asynchronous here, so it works with no clock.
   // Registers only; all decisions are made in the block above.
   always_ff @(posedge mclk_i or posedge in_reset) begin
      if (in_reset) begin
         state_reg <= slpc_pkg::ST_RESET;
         cnt_reg <= '0;
         mode_reg <= `SLPC_MODE_IDLE;
         gate_reg <= 5'h1E;
         sys_rst_n_reg <= 1'b0;
         cpu_en_reg <= 1'b0;
         asleep_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         mode_reg <= mode_next;
         gate_reg <= gate_next;
         sys_rst_n_reg <= sys_rst_n_next;
         cpu_en_reg <= cpu_en_next;
         asleep_reg <= asleep_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Every output is a flip-flop, so no clock gate can glitch.
   assign cpu_clk_en_o = cpu_en_reg;
   assign io_clk_en_o = gate_reg[1];
   assign adc_clk_en_o = gate_reg[2];
   assign async_tmr_en_o = gate_reg[3];
   assign osc_en_o = gate_reg[4];
   assign sys_reset_n_o = sys_rst_n_reg;
   assign asleep_o = asleep_reg;
endmodule // slpc_ctrl
`default_nettype wire

// ==== slpc_cfg.svh ====
// Timing counts and mode codes for the sleep and reset controller.
`ifndef SLPC_CFG_SVH
`define SLPC_CFG_SVH
`define SLPC_MODE_IDLE 3'h0
`define SLPC_MODE_NOISE 3'h1
`define SLPC_MODE_PDOWN 3'h2
`define SLPC_MODE_PSAVE 3'h3
`define SLPC_MODE_STBY 3'h6
`define SLPC_MODE_XSTBY 3'h7
`define SLPC_CLK_MHZ 25
`define SLPC_OSC_START_US 100
`define SLPC_OSC_START_CYC (`SLPC_OSC_START_US * `SLPC_CLK_MHZ)
`define SLPC_RST_MIN_NS 1500
`define SLPC_RST_MIN_CYC ((`SLPC_RST_MIN_NS + 39) / 40)
`define SLPC_CNT_W 12
`endif

// ==== slpc_pkg.sv ====
// Types shared by the sleep and reset controller files.
`default_nettype none
package slpc_pkg;
   typedef enum logic [2:0] {
      ST_RUN = 3'h0,
      ST_SLEEP = 3'h1,
      ST_OSC_WAIT = 3'h2,
      ST_RESET = 3'h3
   } slpc_state_t;
endpackage
`default_nettype wire

// ==== slpc_sync.sv ====
// Two-stage synchroniser for one level from outside the clock domain.
`default_nettype none
module slpc_sync (
   input wire logic mclk_i, // Clock.
   input wire logic reset_n_i, // Asynchronous reset, active low.
   input wire logic d_i, // Asynchronous level.
   output logic q_o // Synchronised level.
);
   logic meta_reg;
   logic q_reg;

   // Only the second stage is read outside.
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_reg <= 1'b0;
         q_reg <= 1'b0;
      end else begin
         meta_reg <= d_i;
         q_reg <= meta_reg;
      end
   end
   assign q_o = q_reg;
endmodule // slpc_sync
`default_nettype wire

// ==== slpc_props.sv ====
// Checker for the sleep and reset controller.
`include "slpc_cfg.svh"
`default_nettype none
module slpc_props (
   input wire logic mclk_i, // Clock.
   input wire logic reset_n_i, // Reset.
   input wire logic ext_reset_n_i, // Pin.
   input wire logic sleep_req_i, // Request.
   input wire logic sleep_en_i, // Enable.
   input wire logic [2:0] sleep_mode_i, // Mode.
   input wire logic [31:0] port_oe_n_o, // Pads.
   input wire logic cpu_clk_en_o, // Cpu.
   input wire logic io_clk_en_o, // Io.
   input wire logic adc_clk_en_o, // Adc.
   input wire logic async_tmr_en_o, // Timer.
   input wire logic osc_en_o, // Osc.
   input wire logic sys_reset_n_o, // Core reset.
   input wire logic asleep_o // Asleep.
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   // A sleep instruction accepted while the core runs.
   sequence s_take(logic [2:0] m);
      cpu_clk_en_o && sleep_req_i && sleep_en_i && sleep_mode_i == m;
   endsequence
   // The pin reset acts without waiting for the synchroniser.
   property p_pads; !ext_reset_n_i |-> port_oe_n_o == 32'hFFFFFFFF; endproperty
   a_pads: assert property (p_pads) else $error("pads driven in reset");
   property p_rst; !ext_reset_n_i |-> !sys_reset_n_o; endproperty
   a_rst: assert property (p_rst) else $error("core reset missing");
   property p_idle;
      s_take(`SLPC_MODE_IDLE) |=> asleep_o && !cpu_clk_en_o && io_clk_en_o && adc_clk_en_o;
   endproperty
   a_idle: assert property (p_idle) else $error("idle gates wrong");
   property p_pdown;
      s_take(`SLPC_MODE_PDOWN) |=> asleep_o && !osc_en_o && !async_tmr_en_o && !io_clk_en_o;
   endproperty
   a_pdown: assert property (p_pdown) else $error("power-down gates wrong");
   property p_psave;
      s_take(`SLPC_MODE_PSAVE) |=> async_tmr_en_o && !io_clk_en_o && !osc_en_o;
   endproperty
   a_psave: assert property (p_psave) else $error("power-save gates wrong");
   property p_noise;
      s_take(`SLPC_MODE_NOISE) |=> adc_clk_en_o && async_tmr_en_o && !io_clk_en_o;
   endproperty
   a_noise: assert property (p_noise) else $error("noise gates wrong");
   property p_stby;
      s_take(`SLPC_MODE_STBY) |=> osc_en_o && !async_tmr_en_o && !io_clk_en_o;
   endproperty
   a_stby: assert property (p_stby) else $error("standby gates wrong");
   property p_xstby;
      s_take(`SLPC_MODE_XSTBY) |=> osc_en_o && async_tmr_en_o && !adc_clk_en_o;
   endproperty
   a_xstby: assert property (p_xstby) else $error("ext standby gates wrong");
   // After a cold wake the core clock stays off for at least 8 cycles.
   property p_osc; $fell(asleep_o) && !$past(osc_en_o) |-> !cpu_clk_en_o [*8]; endproperty
   a_osc: assert property (p_osc) else $error("core clock before settle");
endmodule // slpc_props
bind slpc_ctrl slpc_props u_props (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
   .ext_reset_n_i(ext_reset_n_i), .sleep_req_i(sleep_req_i), .sleep_en_i(sleep_en_i),
   .sleep_mode_i(sleep_mode_i), .port_oe_n_o(port_oe_n_o), .cpu_clk_en_o(cpu_clk_en_o),
   .io_clk_en_o(io_clk_en_o), .adc_clk_en_o(adc_clk_en_o), .async_tmr_en_o(async_tmr_en_o),
   .osc_en_o(osc_en_o), .sys_reset_n_o(sys_reset_n_o), .asleep_o(asleep_o));
`default_nettype wire

// ==== slpc_cpu_model.sv ====
// Core-side partner that issues sleep instructions and drives pad enables.
`default_nettype none
module slpc_cpu_model (
   input wire logic mclk_i, // Clock.
   input wire logic sys_reset_n_i, // Core reset.
   output logic sleep_req_o, // Sleep pulse.
   output logic sleep_en_o, // Sleep enable.
   output logic [2:0] sleep_mode_o, // Mode code.
   output logic [31:0] port_oe_n_o // Pad enables.
);
   timeunit 1ns;
   timeprecision 1ns;
   // A core held in reset drives nothing, so its enables read released.
   assign port_oe_n_o = sys_reset_n_i ? 32'h0F0F0F0F : 32'hFFFFFFFF;
   initial begin
      sleep_req_o = 1'b0;
      sleep_en_o = 1'b0;
      sleep_mode_o = 3'h5;
   end
   // One-cycle sleep instruction; the mode code is not held afterwards.
   task automatic do_sleep(input logic [2:0] m);
      @(posedge mclk_i);
      #1 sleep_req_o = 1'b1;
      sleep_en_o = 1'b1;
      sleep_mode_o = m;
      @(posedge mclk_i);
      #1 sleep_req_o = 1'b0;
      sleep_mode_o = ~m;
      @(posedge mclk_i);
      #1;
   endtask
endmodule // slpc_cpu_model
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the sleep and reset controller.
`include "slpc_cfg.svh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk_i = 1'b0, reset_n_i = 1'b0, ext_reset_n_i = 1'b1, ext_irq_i = 1'b0;
   logic test_en_i = 1'b0, tap_shift_i = 1'b0, per_irq_i = 1'b0, timer_irq_i = 1'b0;
   logic sleep_req_i, sleep_en_i, tdo_oe_n_o, cpu_clk_en_o, io_clk_en_o, adc_clk_en_o;
   logic async_tmr_en_o, osc_en_o, sys_reset_n_o, asleep_o;
   logic [2:0] sleep_mode_i, test_pu_o;
   logic [31:0] port_oe_n_i, port_oe_n_o;
   int errors = 0, checks = 0, n;
   // Clock of 40 ns period.
   always #20 mclk_i = ~mclk_i;
   slpc_cpu_model cpu (.mclk_i(mclk_i), .sys_reset_n_i(sys_reset_n_o),
      .sleep_req_o(sleep_req_i), .sleep_en_o(sleep_en_i), .sleep_mode_o(sleep_mode_i),
      .port_oe_n_o(port_oe_n_i));
   slpc_ctrl dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .ext_reset_n_i(ext_reset_n_i),
      .sleep_req_i(sleep_req_i), .sleep_en_i(sleep_en_i), .sleep_mode_i(sleep_mode_i),
      .ext_irq_i(ext_irq_i), .per_irq_i(per_irq_i), .timer_irq_i(timer_irq_i),
      .test_en_i(test_en_i), .tap_shift_i(tap_shift_i), .port_oe_n_i(port_oe_n_i),
      .port_oe_n_o(port_oe_n_o), .tdo_oe_n_o(tdo_oe_n_o), .test_pu_o(test_pu_o),
      .cpu_clk_en_o(cpu_clk_en_o), .io_clk_en_o(io_clk_en_o), .adc_clk_en_o(adc_clk_en_o),
      .async_tmr_en_o(async_tmr_en_o), .osc_en_o(osc_en_o), .sys_reset_n_o(sys_reset_n_o),
      .asleep_o(asleep_o));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Bounded wait for the core clock; the count tells a cold wake from a warm one.
   task automatic wait_run();
      n = 0;
      while (cpu_clk_en_o !== 1'b1) begin
         @(posedge mclk_i);
         #1 n++;
         if (n > 3000) begin
            errors++;
            end_sim();
         end
      end
      #1;
   endtask
   // Pin reset held past the minimum, with test access enabled until the last test data enable check.
   task automatic t_pin();
      test_en_i = 1'b1;
      tap_shift_i = 1'b1;
      @(posedge mclk_i);
      #1 ext_reset_n_i = 1'b0;
      #2 check(port_oe_n_o, 32'hFFFFFFFF);
      check(sys_reset_n_o, 1'b0);
      check(test_pu_o, 3'h7);
      repeat (`SLPC_RST_MIN_CYC + 2) @(posedge mclk_i);
      #1 ext_reset_n_i = 1'b1;
      wait_run();
      // The pad register takes the released core's enables one edge later.
      @(posedge mclk_i);
      #1 check(port_oe_n_o, 32'h0F0F0F0F);
      check(tdo_oe_n_o, 1'b0);
      #40 tap_shift_i = 1'b0;
      #40 check(tdo_oe_n_o, 1'b1);
      test_en_i = 1'b0;
      #40 check(test_pu_o, 3'h0);
   endtask
   // Peripheral and timer requests wake only the modes that keep their logic running.
   task automatic t_wake();
      cpu.do_sleep(`SLPC_MODE_PSAVE);
      per_irq_i = 1'b1;
      repeat (4) @(posedge mclk_i);
      #1 check(asleep_o, 1'b1);
      timer_irq_i = 1'b1;
      wait_run();
      timer_irq_i = 1'b0;
      per_irq_i = 1'b0;
      check(n > `SLPC_OSC_START_CYC - 10, 1'b1);
      cpu.do_sleep(`SLPC_MODE_IDLE);
      check(asleep_o, 1'b1);
      per_irq_i = 1'b1;
      wait_run();
      per_irq_i = 1'b0;
      check(n < 10, 1'b1);
   endtask
   // Enter a mode, compare the gates, wake by the external interrupt.
   task automatic t_sleep(input logic [2:0] m, input logic [4:0] g);
      cpu.do_sleep(m);
      check({osc_en_o, async_tmr_en_o, adc_clk_en_o, io_clk_en_o, cpu_clk_en_o}, g);
      check(asleep_o, m != 3'h4);
      ext_irq_i = 1'b1;
      wait_run();
      ext_irq_i = 1'b0;
      check(n > `SLPC_OSC_START_CYC - 10, !g[4] && m != 3'h4);
      check(asleep_o, 1'b0);
   endtask
   initial begin
      repeat (3) @(posedge mclk_i);
      #1 reset_n_i = 1'b1;
      wait_run();
      t_pin();
      t_sleep(`SLPC_MODE_IDLE, 5'h1E);
      t_sleep(`SLPC_MODE_NOISE, 5'h1C);
      t_sleep(`SLPC_MODE_PDOWN, 5'h00);
      t_sleep(`SLPC_MODE_PSAVE, 5'h08);
      t_sleep(`SLPC_MODE_STBY, 5'h10);
      t_sleep(`SLPC_MODE_XSTBY, 5'h18);
      t_wake();
      t_sleep(3'h4, 5'h1F);
      end_sim();
   end
endmodule // tb_top
`default_nettype wire
